// [verilog/iscrc_pkg.sv]
// constants shared by the input routing and calibration run register bank
// assumes a 125 MHz clock and a byte-addressed Avalon-MM register port
//
// Contract
// - dual mode, swap clear: channel A takes input a, channel B input b.
// - dual mode, swap set: channel A takes input b, channel B input a.
// - single-channel modes ignore the swap bit completely.
// - single mode select 1 picks input a (default), 2 picks input b.
// - single mode select 3 enters dual interleaved mode: A takes a, B takes b.
// - routing register resets to 0x01.
// - calibration runs while the run bit is 1; it resets to 1.
// - run bit 0 holds the calibration engine in reset.
// - clearing the run bit also resets digital and serial link clock dividers.
package iscrc_pkg;

	localparam int          ISCRC_ADDR_W        = 12;
	localparam int          ISCRC_DATA_W        = 32;
	localparam int          ISCRC_REG_W         = 8;

	// printed offsets are register indices; byte address is four times each
	localparam logic [9:0]  ISCRC_IDX_ROUTING   = 10'h060;
	localparam logic [9:0]  ISCRC_IDX_CAL_RUN   = 10'h061;
	localparam logic [9:0]  ISCRC_IDX_STATUS    = 10'h07F;

	localparam logic [7:0]  ISCRC_ROUTING_RST   = 8'h01;
	localparam logic [7:0]  ISCRC_CAL_RUN_RST   = 8'h01;
	localparam logic [7:0]  ISCRC_STATUS_RST    = 8'h00;

	localparam int          ISCRC_SWAP_BIT      = 4;
	localparam int          ISCRC_SEL_LSB       = 0;
	localparam int          ISCRC_RUN_BIT       = 0;
	localparam int          ISCRC_FAULT_BIT     = 0;
	localparam int          ISCRC_PENDING_BIT   = 1;

	localparam logic [1:0]  ISCRC_SEL_INPUT_A   = 2'h1;
	localparam logic [1:0]  ISCRC_SEL_INPUT_B   = 2'h2;
	localparam logic [1:0]  ISCRC_SEL_INTERLEAVE = 2'h3;

	localparam logic [1:0]  ISCRC_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  ISCRC_RESP_DECERR   = 2'h3;

	typedef enum logic [1:0]
	{
		ISCRC_ST_IDLE = 2'b01,
		ISCRC_ST_ACK  = 2'b10
	} iscrc_state_t;

endpackage : iscrc_pkg

// [verilog/iscrc_input_router.sv]
// converter channel source selection from the routing register fields
// assumes the mode input is steady while the converter is sampling
`timescale 1ns/10ps

module iscrc_input_router
	import iscrc_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       single_channel_mode,
	input  wire logic       paired_input_swap,
	input  wire logic [1:0] lone_channel_input_select,
	output logic            channel_a_from_b,
	output logic            channel_b_from_a,
	output logic            dual_interleaved_mode
);
	import iscrc_pkg::*;

	typedef struct packed
	{
		logic a_from_b;
		logic b_from_a;
		logic interleaved;
	} iscrc_route_t;

	iscrc_route_t state_reg;
	iscrc_route_t state_next;

	always_comb
	begin
		state_next = '0;
		if (single_channel_mode)
		begin
			// swap bit not looked at here
			case (lone_channel_input_select)
				ISCRC_SEL_INPUT_B:
				begin
					state_next.a_from_b = 1'b1;
					state_next.b_from_a = 1'b0;
				end
				ISCRC_SEL_INTERLEAVE:
				begin
					state_next.interleaved = 1'b1;
				end
				default:
				begin
					// value 0 is undefined; treated like input a
					state_next.b_from_a = 1'b1;
				end
			endcase
		end
		else if (paired_input_swap)
		begin
			state_next.a_from_b = 1'b1;
			state_next.b_from_a = 1'b1;
		end
		else
		begin
			state_next.a_from_b = 1'b0;
			state_next.b_from_a = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign channel_a_from_b      = state_reg.a_from_b;
	assign channel_b_from_a      = state_reg.b_from_a;
	assign dual_interleaved_mode = state_reg.interleaved;

endmodule : iscrc_input_router

// [verilog/iscrc_cal_sequencer.sv]
// calibration engine and divider resets, plus sequencing watch flags
// assumes the serial link enable level is synchronous to clock
`timescale 1ns/10ps

module iscrc_cal_sequencer
	import iscrc_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic calibration_run,
	input  wire logic serial_link_enable,
	input  wire logic interleave_selected,
	input  wire logic clear_fault,
	input  wire logic clear_pending,
	output logic      cal_engine_reset,
	output logic      digital_divider_reset,
	output logic      link_divider_reset,
	output logic      sequence_fault,
	output logic      cal_pending
);
	import iscrc_pkg::*;

	typedef struct packed
	{
		logic run_seen;
		logic eng_rst;
		logic dig_rst;
		logic lnk_rst;
		logic fault;
		logic pending;
	} iscrc_seq_t;

	iscrc_seq_t state_reg;
	iscrc_seq_t state_next;
	logic       run_fall;
	logic       run_rise;

	always_comb
	begin
		run_fall = state_reg.run_seen & ~calibration_run;
		run_rise = ~state_reg.run_seen & calibration_run;
		state_next = state_reg;
		state_next.run_seen = calibration_run;
		state_next.eng_rst = ~calibration_run;
		state_next.dig_rst = ~calibration_run;
		state_next.lnk_rst = ~calibration_run;
		// link still enabled when the run bit drops; set beats clear
		if (run_fall & serial_link_enable)
			state_next.fault = 1'b1;
		else if (clear_fault)
			state_next.fault = 1'b0;
		// interleave chosen: calibration still owed until run restarts with the link disabled, or a status write clears it
		if (interleave_selected)
			state_next.pending = 1'b1;
		else if (clear_pending | (run_rise & ~serial_link_enable))
			state_next.pending = 1'b0;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= '0;
			state_reg.run_seen <= ISCRC_CAL_RUN_RST[ISCRC_RUN_BIT];
		end
		else
			state_reg <= state_next;
	end

	assign cal_engine_reset      = state_reg.eng_rst;
	assign digital_divider_reset = state_reg.dig_rst;
	assign link_divider_reset    = state_reg.lnk_rst;
	assign sequence_fault        = state_reg.fault;
	assign cal_pending           = state_reg.pending;

endmodule : iscrc_cal_sequencer

// [verilog/iscrc_top.sv]
// input routing and calibration run register bank with Avalon-MM slave
// assumes a byte-addressed master that holds its request until waitrequest low
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps

module iscrc_top
	import iscrc_pkg::*;
#(
	parameter int ADDR_W = iscrc_pkg::ISCRC_ADDR_W
)
(
	input  wire logic                            clock,
	input  wire logic                            rst,
	input  wire logic [ADDR_W-1:0]               address,
	input  wire logic                            read,
	input  wire logic                            write,
	input  wire logic [iscrc_pkg::ISCRC_DATA_W-1:0] writedata,
	input  wire logic [3:0]                      byteenable,
	output logic [iscrc_pkg::ISCRC_DATA_W-1:0]   readdata,
	output logic                                 waitrequest,
	output logic [1:0]                           response,
	input  wire logic                            single_channel_mode,
	input  wire logic                            serial_link_enable,
	output logic                                 channel_a_from_b,
	output logic                                 channel_b_from_a,
	output logic                                 dual_interleaved_mode,
	output logic                                 cal_engine_reset,
	output logic                                 digital_divider_reset,
	output logic                                 link_divider_reset,
	output logic                                 sequence_fault
);
	import iscrc_pkg::*;

	generate
		if (ADDR_W < 12)
		begin : g_addr_check
			$error("iscrc_top: ADDR_W must be at least 12");
		end
	endgenerate

	typedef struct packed
	{
		iscrc_state_t                st;
		logic [ISCRC_REG_W-1:0]      routing;
		logic [ISCRC_REG_W-1:0]      cal_run;
		logic [ISCRC_DATA_W-1:0]     rdata;
		logic [1:0]                  resp;
		logic                        hit_routing;
		logic                        hit_cal_run;
		logic                        hit_status;
		logic                        interleave_pulse;
		logic                        clr_fault;
		logic                        clr_pending;
		logic                        wreq;
	} iscrc_bank_t;

	iscrc_bank_t state_reg;
	iscrc_bank_t state_next;

	logic [9:0]             word_index;
	logic                   aligned;
	logic                   hit_routing;
	logic                   hit_cal_run;
	logic                   hit_status;
	logic                   request;
	logic                   low_lane;
	logic [ISCRC_REG_W-1:0] wbyte;
	logic [ISCRC_REG_W-1:0] status_byte;
	logic                   fault_flag;
	logic                   pending_flag;

	assign word_index = address[11:2];
	assign aligned    = (address[1:0] == 2'h0);
	assign request    = read | write;
	assign low_lane   = byteenable[0];
	assign wbyte      = writedata[ISCRC_REG_W-1:0];

	// address decode
	always_comb
	begin
		hit_routing = 1'b0;
		hit_cal_run = 1'b0;
		hit_status  = 1'b0;
		// shift keeps the test legal when ADDR_W is exactly 12
		if (!aligned || ((address >> 12) != '0))
		begin
			hit_routing = 1'b0;
		end
		else if (word_index == ISCRC_IDX_ROUTING)
		begin
			hit_routing = 1'b1;
		end
		else if (word_index == ISCRC_IDX_CAL_RUN)
		begin
			hit_cal_run = 1'b1;
		end
		else if (word_index == ISCRC_IDX_STATUS)
		begin
			hit_status = 1'b1;
		end
	end

	always_comb
	begin
		status_byte = ISCRC_STATUS_RST;
		status_byte[ISCRC_FAULT_BIT]   = fault_flag;
		status_byte[ISCRC_PENDING_BIT] = pending_flag;
	end

	always_comb
	begin
		state_next = state_reg;
		state_next.interleave_pulse = 1'b0;
		state_next.clr_fault        = 1'b0;
		state_next.clr_pending      = 1'b0;
		case (state_reg.st)
			ISCRC_ST_IDLE:
			begin
				if (request)
				begin
					// capture decode and read data; answer next cycle
					state_next.st          = ISCRC_ST_ACK;
					state_next.wreq        = 1'b0;
					state_next.hit_routing = hit_routing;
					state_next.hit_cal_run = hit_cal_run;
					state_next.hit_status  = hit_status;
					state_next.rdata       = '0;
					state_next.resp        = ISCRC_RESP_OKAY;
					if (!(hit_routing | hit_cal_run | hit_status))
					begin
						state_next.resp = ISCRC_RESP_DECERR;
					end
					else if (read && hit_routing)
					begin
						// reserved bits come back as stored
						state_next.rdata[ISCRC_REG_W-1:0] = state_reg.routing;
					end
					else if (read && hit_cal_run)
					begin
						state_next.rdata[ISCRC_REG_W-1:0] = state_reg.cal_run;
					end
					else if (read && hit_status)
					begin
						state_next.rdata[ISCRC_REG_W-1:0] = status_byte;
					end
				end
			end
			ISCRC_ST_ACK:
			begin
				// master still holds the request; write lands on this edge
				state_next.st   = ISCRC_ST_IDLE;
				state_next.wreq = 1'b1;
				if (write && low_lane && state_reg.hit_routing)
				begin
					state_next.routing = wbyte;
					if (wbyte[ISCRC_SEL_LSB +: 2] == ISCRC_SEL_INTERLEAVE)
					begin
						state_next.interleave_pulse = 1'b1;
					end
				end
				else if (write && low_lane && state_reg.hit_cal_run)
				begin
					state_next.cal_run = wbyte;
				end
				else if (write && low_lane && state_reg.hit_status)
				begin
					// write one to clear
					state_next.clr_fault   = wbyte[ISCRC_FAULT_BIT];
					state_next.clr_pending = wbyte[ISCRC_PENDING_BIT];
				end
			end
			default:
			begin
				state_next.st   = ISCRC_ST_IDLE;
				state_next.wreq = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg         <= '0;
			state_reg.st      <= ISCRC_ST_IDLE;
			state_reg.wreq    <= 1'b1;
			state_reg.routing <= ISCRC_ROUTING_RST;
			state_reg.cal_run <= ISCRC_CAL_RUN_RST;
			state_reg.resp    <= ISCRC_RESP_OKAY;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign readdata    = state_reg.rdata;
	assign waitrequest = state_reg.wreq;
	assign response    = state_reg.resp;

	// only the swap bit, the select field and single_channel_mode steer routing
	iscrc_input_router u_router
	(
		.clock                     (clock),
		.rst                       (rst),
		.single_channel_mode       (single_channel_mode),
		.paired_input_swap         (state_reg.routing[ISCRC_SWAP_BIT]),
		.lone_channel_input_select (state_reg.routing[ISCRC_SEL_LSB +: 2]),
		.channel_a_from_b          (channel_a_from_b),
		.channel_b_from_a          (channel_b_from_a),
		.dual_interleaved_mode     (dual_interleaved_mode)
	);

	iscrc_cal_sequencer u_seq
	(
		.clock                 (clock),
		.rst                   (rst),
		.calibration_run       (state_reg.cal_run[ISCRC_RUN_BIT]),
		.serial_link_enable    (serial_link_enable),
		.interleave_selected   (state_reg.interleave_pulse),
		.clear_fault           (state_reg.clr_fault),
		.clear_pending         (state_reg.clr_pending),
		.cal_engine_reset      (cal_engine_reset),
		.digital_divider_reset (digital_divider_reset),
		.link_divider_reset    (link_divider_reset),
		.sequence_fault        (fault_flag),
		.cal_pending           (pending_flag)
	);

	assign sequence_fault = fault_flag;

endmodule : iscrc_top

// [verif/iscrc_checker.sv]
// port assertions for the routing and calibration run register bank
// assumes a bind into iscrc_top with one clock domain
`timescale 1ns/10ps

module iscrc_checker
	import iscrc_pkg::*;
#(
	parameter int ADDR_W = ISCRC_ADDR_W
)
(
	input wire logic              clock,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic              read,
	input wire logic              write,
	input wire logic [31:0]       writedata,
	input wire logic [3:0]        byteenable,
	input wire logic [31:0]       readdata,
	input wire logic              waitrequest,
	input wire logic [1:0]        response,
	input wire logic              single_channel_mode,
	input wire logic              serial_link_enable,
	input wire logic              channel_a_from_b,
	input wire logic              channel_b_from_a,
	input wire logic              dual_interleaved_mode,
	input wire logic              cal_engine_reset,
	input wire logic              digital_divider_reset,
	input wire logic              link_divider_reset,
	input wire logic              sequence_fault
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic mapped;
	logic run_wr;
	assign mapped = address == ADDR_W'(12'h180) || address == ADDR_W'(12'h184)
		|| address == ADDR_W'(12'h1FC);
	assign run_wr = write && !waitrequest && address == ADDR_W'(12'h184) && byteenable[0];

	AST_ACK_ONE: assert property (!waitrequest |=> waitrequest)
		else $error("ack held longer than one cycle");
	AST_ANSWER: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
		else $error("request not answered");
	AST_DECERR: assert property (read && !waitrequest && !mapped |->
		response == ISCRC_RESP_DECERR && readdata == 32'h0)
		else $error("unmapped read not refused");
	AST_DUAL: assert property (!$past(single_channel_mode) |->
		channel_a_from_b == channel_b_from_a && !dual_interleaved_mode)
		else $error("dual mode routing inconsistent");
	AST_SINGLE: assert property ($past(single_channel_mode) |->
		!(channel_a_from_b && channel_b_from_a))
		else $error("single mode routing crossed");
	AST_INTERLEAVE: assert property (dual_interleaved_mode |->
		!channel_a_from_b && !channel_b_from_a)
		else $error("interleave routing wrong");
	AST_DIVIDERS: assert property (cal_engine_reset == digital_divider_reset
		&& cal_engine_reset == link_divider_reset)
		else $error("divider resets differ from engine reset");
	AST_RUN: assert property (run_wr |-> ##2 cal_engine_reset == !$past(writedata[0], 2))
		else $error("run bit write not reflected");
	AST_FAULT: assert property (sequence_fault && !$past(write && !waitrequest
		&& address == ADDR_W'(12'h1FC) && byteenable[0] && writedata[0])
		|=> sequence_fault)
		else $error("fault flag dropped");
endmodule : iscrc_checker

bind iscrc_top iscrc_checker #(.ADDR_W(ADDR_W)) u_chk (.clock(clock), .rst(rst),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
	.response(response), .single_channel_mode(single_channel_mode),
	.serial_link_enable(serial_link_enable), .channel_a_from_b(channel_a_from_b),
	.channel_b_from_a(channel_b_from_a), .dual_interleaved_mode(dual_interleaved_mode),
	.cal_engine_reset(cal_engine_reset), .digital_divider_reset(digital_divider_reset),
	.link_divider_reset(link_divider_reset), .sequence_fault(sequence_fault));

// [verif/iscrc_top_bench.sv]
// self-checking bench for the routing and calibration run register bank
// assumes iscrc_top answers one cycle after taking a request
`timescale 1ns/10ps
`define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end

module iscrc_top_bench;
	import iscrc_pkg::*;
	logic        clock, rst, read, write, single_channel_mode, serial_link_enable;
	logic [11:0] address;
	logic [31:0] writedata, readdata, rd;
	logic [3:0]  byteenable;
	logic [1:0]  response, resp;
	logic        waitrequest, channel_a_from_b, channel_b_from_a, dual_interleaved_mode;
	logic        cal_engine_reset, digital_divider_reset, link_divider_reset, sequence_fault;
	int          miscompares, n_checks;

	iscrc_top dut (.clock(clock), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .response(response),
		.single_channel_mode(single_channel_mode), .serial_link_enable(serial_link_enable),
		.channel_a_from_b(channel_a_from_b), .channel_b_from_a(channel_b_from_a),
		.dual_interleaved_mode(dual_interleaved_mode), .cal_engine_reset(cal_engine_reset),
		.digital_divider_reset(digital_divider_reset),
		.link_divider_reset(link_divider_reset), .sequence_fault(sequence_fault));

	task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= {24'h0, d};
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 20);
		rd = readdata;
		resp = response;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
		if (n >= 20)
			miscompares++;
	endtask : bus

	task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(rd, {24'h0, e})
		`CHK(resp, ISCRC_RESP_OKAY)
	endtask : rdchk

	task automatic route(input logic s, input logic [7:0] v, input logic [2:0] e);
		single_channel_mode <= s;
		bus(1'b1, 12'h180, v);
		repeat (2) @(posedge clock);
		`CHK({channel_a_from_b, channel_b_from_a, dual_interleaved_mode}, e)
	endtask : route

	task automatic t_reset;
		rdchk(12'h180, 8'h01);
		rdchk(12'h184, 8'h01);
		`CHK({channel_a_from_b, channel_b_from_a, dual_interleaved_mode}, 3'b010)
		`CHK(cal_engine_reset, 1'b0)
	endtask : t_reset

	task automatic t_single;
		route(1'b1, 8'h11, 3'b010);
		route(1'b1, 8'h12, 3'b100);
		route(1'b1, 8'h13, 3'b001);
		rdchk(12'h1FC, 8'h02);
		bus(1'b1, 12'h184, 8'h00);
		bus(1'b1, 12'h184, 8'h01);
		rdchk(12'h1FC, 8'h00);
	endtask : t_single

	task automatic t_dual;
		route(1'b0, 8'h00, 3'b000);
		route(1'b0, 8'h13, 3'b110);
		route(1'b0, 8'hE3, 3'b000);
		rdchk(12'h180, 8'hE3);
	endtask : t_dual

	task automatic t_cal;
		serial_link_enable <= 1'b0;
		bus(1'b1, 12'h184, 8'hFE);
		repeat (2) @(posedge clock);
		`CHK({cal_engine_reset, digital_divider_reset, link_divider_reset}, 3'b111)
		rdchk(12'h184, 8'hFE);
		bus(1'b1, 12'h184, 8'h01);
		repeat (2) @(posedge clock);
		`CHK({cal_engine_reset, digital_divider_reset, link_divider_reset}, 3'b000)
		serial_link_enable <= 1'b1;
	endtask : t_cal

	task automatic t_fault;
		bus(1'b1, 12'h184, 8'h00);
		serial_link_enable <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK(sequence_fault, 1'b1)
		rdchk(12'h1FC, 8'h01);
		bus(1'b1, 12'h1FC, 8'h01);
		bus(1'b1, 12'h184, 8'h01);
		`CHK(sequence_fault, 1'b0)
		bus(1'b0, 12'h100, 8'h00);
		`CHK({resp, rd}, {ISCRC_RESP_DECERR, 32'h0})
	endtask : t_fault

	task automatic give_verdict;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial
	begin
		repeat (3000) @(posedge clock);
		miscompares++;
		give_verdict();
	end

	initial
	begin
		rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 12'h0;
		writedata = 32'h0;
		byteenable = 4'hF;
		single_channel_mode = 1'b1;
		serial_link_enable = 1'b0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_reset();
		t_single();
		t_dual();
		t_cal();
		t_fault();
		give_verdict();
	end
endmodule : iscrc_top_bench
